//--- dcam_map.sv
`timescale 1ns/1ps
`default_nettype none
module dcam_map (
	input  wire logic                               clk,              // 250 MHz clock
	input  wire logic                               srst,             // sync reset
	input  wire logic                               req_valid,        // host request
	output logic                                    req_ready,        // request taken
	input  wire logic [dcam_pkg::ADDR_W-1:0]        req_addr,         // byte address
	input  wire logic                               req_write,        // write request
	input  wire logic [dcam_pkg::DM_W-1:0]          req_be,           // byte enables
	input  wire logic [dcam_pkg::DATA_W-1:0]        req_wdata,        // write data
	output logic                                    resp_err,         // request out of range
	output logic                                    rd_valid,         // read data valid
	output logic [dcam_pkg::DATA_W-1:0]             rd_data,          // read data
	input  wire dcam_pkg::dcam_mode_e               cfg_mode,         // channel mode
	input  wire logic                               cfg_single_ch,    // channel in single mode
	input  wire logic [dcam_pkg::SIZE_W-1:0]        cfg_ch0_size,     // channel 0, 64 MB units
	input  wire logic [dcam_pkg::SIZE_W-1:0]        cfg_ch1_size,     // channel 1, 64 MB units
	input  wire logic [1:0]                         cfg_density,      // device density
	input  wire logic                               cfg_x16,          // x16 devices
	input  wire logic                               cfg_full_variant, // 4 GB / 667 capable
	input  wire logic [2*dcam_pkg::SLOTS-1:0]       dimm_speed,       // per slot speed grade
	input  wire logic [dcam_pkg::SLOTS-1:0]         dimm_cl444,       // per slot 4-4-4 timing
	input  wire logic [dcam_pkg::SLOTS-1:0]         dimm_registered,  // per slot registered
	input  wire logic [dcam_pkg::SLOTS-1:0]         dimm_ecc,         // per slot ecc
	input  wire logic                               suspend_req,      // enter suspend-to-RAM
	output logic                                    ch0_cmd_valid,    // command to channel 0
	output logic                                    ch1_cmd_valid,    // command to channel 1
	output logic                                    cmd_write,        // command is write
	output logic                                    cmd_page_hit,     // row already open
	output logic [1:0]                              cmd_rank,         // rank
	output logic [2:0]                              cmd_bank,         // bank
	output logic [dcam_pkg::ROW_W-1:0]              cmd_row,          // row
	output logic [dcam_pkg::COL_W-1:0]              cmd_col,          // column
	output logic [3:0]                              cmd_burst_len,    // burst length
	output logic [dcam_pkg::DATA_W-1:0]             ch0_wdata,        // channel 0 data lines
	output logic [dcam_pkg::DATA_W-1:0]             ch1_wdata,        // channel 1 data lines
	output logic [dcam_pkg::DM_W-1:0]               ch0_dm,           // channel 0 data mask
	output logic [dcam_pkg::DM_W-1:0]               ch1_dm,           // channel 1 data mask
	input  wire logic                               ch0_rd_valid,     // channel 0 read return
	input  wire logic [dcam_pkg::DATA_W-1:0]        ch0_rd_data,      // channel 0 read data
	input  wire logic                               ch1_rd_valid,     // channel 1 read return
	input  wire logic [dcam_pkg::DATA_W-1:0]        ch1_rd_data,      // channel 1 read data
	output logic                                    ch0_cke,          // channel 0 clock enable
	output logic                                    ch1_cke,          // channel 1 clock enable
	output logic [1:0]                              mem_speed,        // common speed grade
	output logic                                    cfg_error,        // configuration refused
	output logic                                    suspended,        // in suspend-to-RAM
	output logic [5:0]                              open_pages        // open pages, both channels
);
	import dcam_pkg::*;

	typedef struct packed {
		logic [1:0]        ch_valid;
		logic              write;
		logic              hit;
		logic [1:0]        rank;
		logic [2:0]        bank;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
		logic [DATA_W-1:0] wdata;
		logic [DM_W-1:0]   dm;
		logic [1:0]        cke;
		logic              ready;
		logic              suspended;
		logic              err;
		logic              cfg_error;
		logic [1:0]        speed;
		logic              rd_valid;
		logic [DATA_W-1:0] rd_data;
		logic [5:0]        open_pages;
	} dcam_state_s;

	dcam_state_s s;
	dcam_state_s next_s;

	logic [1:0]        min_spd;
	logic              any_444;
	logic              bad_module;
	logic [1:0]        populated;
	logic [SIZE_W:0]   total;
	logic [SIZE_W-1:0] limit;
	logic              cfg_ok;
	logic              accept;
	logic              chan;
	logic [ADDR_W:0]   boundary;
	logic [ADDR_W:0]   a33;
	logic [ADDR_W-1:0] local_addr;
	logic [ADDR_W:0]   chan_top;
	logic              addr_ok;
	logic              eight_bank;
	logic [5:0]        rank_shift;
	logic [5:0]        row_lsb;
	logic [ADDR_W-1:0] row_mask;
	logic [1:0]        map_rank;
	logic [2:0]        map_bank;
	logic [ROW_W-1:0]  map_row;
	logic [1:0]        pt_hit;
	logic [1:0][4:0]   pt_count;
	logic              go_susp;

	always_comb
	begin
		min_spd = SPD_NONE;
		any_444 = 1'b0;
		bad_module = 1'b0;
		// slowest installed module sets the pace of both channels
		for (int i = 0; i < SLOTS; i++)
		begin
			if (dimm_speed[2*i +: 2] != SPD_NONE)
			begin
				if (min_spd == SPD_NONE || dimm_speed[2*i +: 2] < min_spd)
					min_spd = dimm_speed[2*i +: 2];
				any_444 = any_444 | dimm_cl444[i];
				bad_module = bad_module | dimm_registered[i] | dimm_ecc[i];
			end
		end
		if (!cfg_full_variant && min_spd == SPD_667)
			min_spd = SPD_533;
	end

	always_comb
	begin
		populated = {cfg_ch1_size != '0, cfg_ch0_size != '0};
		total = {1'b0, cfg_ch0_size} + {1'b0, cfg_ch1_size};
		limit = cfg_full_variant ? LIMIT_FULL : LIMIT_REDUCED;
		cfg_ok = !bad_module
			&& !(min_spd == SPD_667 && any_444)
			&& cfg_density != 2'h3
			&& total <= {1'b0, limit}
			&& min_spd != SPD_NONE;
		unique case (cfg_mode)
			MODE_SINGLE: cfg_ok = cfg_ok && populated[cfg_single_ch];
			MODE_ASYM: cfg_ok = cfg_ok && populated[0];
			MODE_INTERLEAVE: cfg_ok = cfg_ok && (populated == 2'h3)
				&& (cfg_ch0_size == cfg_ch1_size);
			default: cfg_ok = 1'b0;
		endcase
	end

	assign accept = req_valid && s.ready;

	always_comb
	begin
		boundary = {cfg_ch0_size, {SIZE_LSB{1'b0}}};
		a33 = {1'b0, req_addr};
		chan = 1'b0;
		local_addr = req_addr;
		unique case (cfg_mode)
			MODE_SINGLE: chan = cfg_single_ch;
			MODE_ASYM:
			begin
				// channel 1 starts where channel 0 ends
				if (a33 >= boundary)
				begin
					chan = 1'b1;
					local_addr = ADDR_W'(a33 - boundary);
				end
			end
			MODE_INTERLEAVE:
			begin
				chan = req_addr[LINE_SEL_BIT];
				local_addr = {1'b0, req_addr[ADDR_W-1:LINE_SEL_BIT+1],
					req_addr[LINE_SEL_BIT-1:0]};
			end
			default: chan = 1'b0;
		endcase
		chan_top = chan ? {cfg_ch1_size, {SIZE_LSB{1'b0}}} : boundary;
		addr_ok = ({1'b0, local_addr} < chan_top)
			&& (a33 < {limit, {SIZE_LSB{1'b0}}});
	end

	// rank spans eight x8 or four x16 devices, so x8 ranks are twice as big
	always_comb
	begin
		eight_bank = (cfg_density == DENS_1G);
		rank_shift = 6'(RANK_LSB_BASE) + {4'h0, cfg_density} + {5'h0, !cfg_x16};
		row_lsb = eight_bank ? 6'(BANK_LSB + 3) : 6'(BANK_LSB + 2);
		row_mask = (32'h1 << (rank_shift - row_lsb)) - 32'h1;
		map_rank = 2'(local_addr >> rank_shift);
		map_bank = eight_bank ? local_addr[BANK_LSB +: 3] : {1'b0, local_addr[BANK_LSB +: 2]};
		map_row = ROW_W'((local_addr >> row_lsb) & row_mask);
	end

	assign go_susp = suspend_req && !accept && (s.ch_valid == 2'h0);

	always_comb
	begin
		next_s = s;
		next_s.ch_valid = 2'h0;
		next_s.err = 1'b0;
		if (accept)
		begin
			if (addr_ok)
			begin
				next_s.ch_valid[chan] = 1'b1;
				next_s.write = req_write;
				next_s.hit = pt_hit[chan];
				next_s.rank = map_rank;
				next_s.bank = map_bank;
				next_s.row = map_row;
				next_s.col = local_addr[COL_LSB +: COL_W];
				next_s.wdata = req_wdata;
				// masked lanes keep their old bytes without a read
				next_s.dm = req_write ? ~req_be : '0;
			end
			else
				next_s.err = 1'b1;
		end
		if (go_susp)
			next_s.suspended = 1'b1;
		else if (!suspend_req)
			next_s.suspended = 1'b0;
		next_s.ready = cfg_ok && !suspend_req && !next_s.suspended;
		for (int i = 0; i < 2; i++)
			next_s.cke[i] = populated[i] && !next_s.suspended
				&& (cfg_mode != MODE_SINGLE || cfg_single_ch == 1'(i));
		next_s.cfg_error = !cfg_ok;
		next_s.speed = min_spd;
		next_s.rd_valid = ch0_rd_valid | ch1_rd_valid;
		next_s.rd_data = ch0_rd_valid ? ch0_rd_data : ch1_rd_data;
		next_s.open_pages = {1'b0, pt_count[0]} + {1'b0, pt_count[1]};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_pt
		dcam_page_track u_pt (
			.clk        (clk),
			.srst       (srst),
			.commit     (accept && addr_ok && chan == 1'(g)),
			.idx        ({map_rank[0], map_bank}),
			.tag        ({map_rank[1], map_row}),
			.close_all  (s.suspended),
			.hit        (pt_hit[g]),
			.open_count (pt_count[g])
		);
	end

	assign req_ready = s.ready;
	assign resp_err = s.err;
	assign rd_valid = s.rd_valid;
	assign rd_data = s.rd_data;
	assign ch0_cmd_valid = s.ch_valid[0];
	assign ch1_cmd_valid = s.ch_valid[1];
	assign cmd_write = s.write;
	assign cmd_page_hit = s.hit;
	assign cmd_rank = s.rank;
	assign cmd_bank = s.bank;
	assign cmd_row = s.row;
	assign cmd_col = s.col;
	assign cmd_burst_len = BURST_LEN;
	assign ch0_wdata = s.wdata;
	assign ch1_wdata = s.wdata;
	assign ch0_dm = s.dm;
	assign ch1_dm = s.dm;
	assign ch0_cke = s.cke[0];
	assign ch1_cke = s.cke[1];
	assign mem_speed = s.speed;
	assign cfg_error = s.cfg_error;
	assign suspended = s.suspended;
	assign open_pages = s.open_pages;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence il_take_s;
		accept && addr_ok && cfg_mode == MODE_INTERLEAVE;
	endsequence
	sequence il_issue_s;
		(ch1_cmd_valid == $past(req_addr[LINE_SEL_BIT])) && (ch0_cmd_valid != ch1_cmd_valid);
	endsequence

	interleave_swap_a: assert property (il_take_s |=> il_issue_s)
		else $error("interleave picked wrong channel");
	asym_stack_a: assert property (accept && addr_ok && cfg_mode == MODE_ASYM
		&& a33 < boundary |=> ch0_cmd_valid && !ch1_cmd_valid)
		else $error("asymmetric low address left channel 0");
	single_idle_a: assert property ($stable(cfg_mode) && $stable(cfg_single_ch)
		&& cfg_mode == MODE_SINGLE && !cfg_single_ch |=> !ch1_cmd_valid && !ch1_cke)
		else $error("idle channel active in single mode");
	burst_len_a: assert property (ch0_cmd_valid || ch1_cmd_valid |-> cmd_burst_len == 4'h8)
		else $error("burst length not eight");
	dm_partial_a: assert property (accept && addr_ok && req_write
		|=> cmd_write && ch0_dm == ~$past(req_be))
		else $error("data mask does not match byte enables");
	bank_count_a: assert property (accept && addr_ok && cfg_density != DENS_1G
		|=> cmd_bank[2] == 1'b0)
		else $error("eighth bank used on small device");
	susp_cke_a: assert property (suspended |-> !ch0_cke && !ch1_cke && !req_ready)
		else $error("clock enable high during suspend");
	page_limit_a: assert property (open_pages <= MAX_OPEN_PAGES)
		else $error("too many open pages");
	bad_dimm_a: assert property ((|(dimm_registered | dimm_ecc)) && $stable(dimm_speed)
		&& (dimm_speed[1:0] != SPD_NONE) && (dimm_registered[0] || dimm_ecc[0])
		|=> cfg_error && !req_ready)
		else $error("registered or ecc module accepted");
	size_limit_a: assert property (accept && !cfg_full_variant && req_addr[ADDR_W-1]
		|=> resp_err && !ch0_cmd_valid && !ch1_cmd_valid)
		else $error("address above reduced limit served");
	slow_speed_a: assert property ($stable(dimm_speed) && dimm_speed[1:0] == SPD_400
		|=> mem_speed == SPD_400)
		else $error("speed above slowest module");
endmodule : dcam_map
`default_nettype wire

//--- dcam_pkg.sv
// Function
// - each channel carries 64 data lines; one or two channels may be populated.
// - asymmetric mode places channel 1 addresses after all of channel 0.
// - interleaved mode swaps channel at every 64-byte cache line boundary.
// - all channels run at one speed, that of the slowest DIMM; the reduced variant caps 667 at 533.
// - 400, 533 and 667 grades supported; 667 with 4-4-4 timing refused.
// - 256 Mb, 512 Mb and 1 Gb devices, x8 or x16, are supported.
// - four banks up to 512 Mb devices, eight banks for 1 Gb devices.
// - every access uses a burst length of eight in all modes.
// - in dual-channel mode no more than 32 pages are open at once.
// - partial writes use data mask lines, never read-modify-write.
// - only unbuffered non-ECC DIMMs; registered or ECC modules are refused.
// - suspend-to-RAM keeps contents by dropping DIMM clock enable.
// - total memory at most 4 GB full variant, 2 GB reduced variant.
// - a rank is eight x8 or four x16 devices across 64 bits.
package dcam_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int DM_W = 8;
	localparam int SIZE_W = 7;
	localparam int SIZE_LSB = 26;
	localparam int LINE_SEL_BIT = 6;
	localparam int COL_LSB = 3;
	localparam int COL_W = 10;
	localparam int BANK_LSB = 13;
	localparam int ROW_W = 14;
	localparam int RANK_LSB_BASE = 27;
	localparam int PAGES_PER_CH = 16;
	localparam int PAGE_IDX_W = 4;
	localparam int PAGE_TAG_W = 15;
	localparam int SLOTS = 4;
	localparam logic [5:0] MAX_OPEN_PAGES = 6'h20;
	localparam logic [3:0] BURST_LEN = 4'h8;
	localparam logic [SIZE_W-1:0] LIMIT_FULL = 7'h40;
	localparam logic [SIZE_W-1:0] LIMIT_REDUCED = 7'h20;
	localparam logic [1:0] SPD_NONE = 2'h0;
	localparam logic [1:0] SPD_400 = 2'h1;
	localparam logic [1:0] SPD_533 = 2'h2;
	localparam logic [1:0] SPD_667 = 2'h3;
	localparam logic [1:0] DENS_256M = 2'h0;
	localparam logic [1:0] DENS_512M = 2'h1;
	localparam logic [1:0] DENS_1G = 2'h2;
	typedef enum logic [1:0] {MODE_SINGLE, MODE_ASYM, MODE_INTERLEAVE} dcam_mode_e;
endpackage : dcam_pkg

//--- dcam_page_track.sv
`timescale 1ns/1ps
`default_nettype none
module dcam_page_track (
	input  wire logic                              clk,       // clock
	input  wire logic                              srst,      // sync reset
	input  wire logic                              commit,    // access issued here
	input  wire logic [dcam_pkg::PAGE_IDX_W-1:0]   idx,       // rank lsb and bank
	input  wire logic [dcam_pkg::PAGE_TAG_W-1:0]   tag,       // rank msb and row
	input  wire logic                              close_all, // precharge all
	output logic                                   hit,       // page already open
	output logic [4:0]                             open_count // pages open
);
	import dcam_pkg::*;

	typedef struct packed {
		logic [PAGES_PER_CH-1:0]                 vld;
		logic [PAGES_PER_CH-1:0][PAGE_TAG_W-1:0] tags;
		logic [4:0]                              count;
	} dcam_pt_s;

	dcam_pt_s s;
	dcam_pt_s next_s;

	assign hit = s.vld[idx] && (s.tags[idx] == tag);
	assign open_count = s.count;

	// one slot per bank index bounds this channel to 16 open pages
	always_comb
	begin
		next_s = s;
		if (close_all)
			next_s.vld = '0;
		else if (commit)
		begin
			next_s.vld[idx] = 1'b1;
			next_s.tags[idx] = tag;
		end
		next_s.count = '0;
		for (int i = 0; i < PAGES_PER_CH; i++)
			next_s.count = next_s.count + 5'(next_s.vld[i]);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end
endmodule : dcam_page_track
`default_nettype wire

//--- dcam_dimm_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcam_dimm_model #(
	parameter int LAT = 2
) (
	input  wire logic        clk,       // controller clock
	input  wire logic        cke,       // clock enable
	input  wire logic        cmd_valid, // command for this channel
	input  wire logic        cmd_write, // write command
	input  wire logic [28:0] addr,      // rank, bank, row, column
	input  wire logic [63:0] wdata,     // data lines
	input  wire logic [7:0]  dm,        // 1 keeps the byte
	output logic             rd_valid,  // read return
	output logic [63:0]      rd_data    // read data
);
	logic [63:0] mem [logic [28:0]];
	logic [63:0] t;
	logic [63:0] word = 64'h0;
	int          cnt = 0;
	initial rd_valid = 1'h0;
	initial rd_data = 64'h0;
	always @(posedge clk)
	begin
		rd_valid <= 1'h0;
		rd_data <= ~word; // a released bus never repeats the last word
		if (cnt > 0)
			cnt <= cnt - 1;
		if (cnt == 1)
		begin
			rd_valid <= 1'h1;
			rd_data <= word;
		end
		if (cke && cmd_valid)
		begin
			t = mem.exists(addr) ? mem[addr] : {35'h0, addr};
			for (int b = 0; b < 8; b++)
				if (cmd_write && !dm[b])
					t[8*b +: 8] = wdata[8*b +: 8];
			mem[addr] = t;
			if (!cmd_write)
			begin
				word <= t;
				cnt <= LAT;
			end
		end
	end
endmodule : dcam_dimm_model
`default_nettype wire

//--- dcam_map_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcam_map_tb_top;
	import dcam_pkg::*;
	logic        clk = 1'h0, srst = 1'h1, req_valid = 1'h0, req_write = 1'h0;
	logic        suspend_req = 1'h0, cfg_single_ch = 1'h0, cfg_x16 = 1'h0, cfg_full_variant = 1'h1;
	logic        req_ready, resp_err, rd_valid, ch0_cmd_valid, ch1_cmd_valid, cmd_write;
	logic        cmd_page_hit, ch0_rd_valid, ch1_rd_valid, ch0_cke, ch1_cke, cfg_error, suspended;
	logic [31:0] req_addr = 32'h0, a;
	logic [7:0]  req_be = 8'hFF, dimm_speed = 8'h0F, ch0_dm, ch1_dm;
	logic [63:0] req_wdata = 64'h0, rd_data, ch0_wdata, ch1_wdata, ch0_rd_data, ch1_rd_data;
	logic [6:0]  cfg_ch0_size = 7'h10, cfg_ch1_size = 7'h0;
	logic [3:0]  dimm_cl444 = 4'h0, dimm_registered = 4'h0, dimm_ecc = 4'h0, cmd_burst_len;
	logic [1:0]  cfg_density = 2'h1, cmd_rank, mem_speed;
	logic [2:0]  cmd_bank;
	logic [13:0] cmd_row;
	logic [9:0]  cmd_col;
	logic [5:0]  open_pages;
	dcam_mode_e  cfg_mode = MODE_SINGLE;
	int          errors = 0, n_tests = 0;

	always #2 clk = ~clk;

	dcam_map i_dcam_map (.clk, .srst, .req_valid, .req_ready, .req_addr, .req_write, .req_be,
		.req_wdata, .resp_err, .rd_valid, .rd_data, .cfg_mode, .cfg_single_ch, .cfg_ch0_size,
		.cfg_ch1_size, .cfg_density, .cfg_x16, .cfg_full_variant, .dimm_speed, .dimm_cl444,
		.dimm_registered, .dimm_ecc, .suspend_req, .ch0_cmd_valid, .ch1_cmd_valid, .cmd_write,
		.cmd_page_hit, .cmd_rank, .cmd_bank, .cmd_row, .cmd_col, .cmd_burst_len, .ch0_wdata,
		.ch1_wdata, .ch0_dm, .ch1_dm, .ch0_rd_valid, .ch0_rd_data, .ch1_rd_valid, .ch1_rd_data,
		.ch0_cke, .ch1_cke, .mem_speed, .cfg_error, .suspended, .open_pages);
	// unequal latencies so channel 0 returns prompt and channel 1 slow
	dcam_dimm_model #(.LAT(2)) u_dimm0 (.clk, .cke(ch0_cke), .cmd_valid(ch0_cmd_valid), .cmd_write,
		.addr({cmd_rank, cmd_bank, cmd_row, cmd_col}), .wdata(ch0_wdata), .dm(ch0_dm),
		.rd_valid(ch0_rd_valid), .rd_data(ch0_rd_data));
	dcam_dimm_model #(.LAT(9)) u_dimm1 (.clk, .cke(ch1_cke), .cmd_valid(ch1_cmd_valid), .cmd_write,
		.addr({cmd_rank, cmd_bank, cmd_row, cmd_col}), .wdata(ch1_wdata), .dm(ch1_dm),
		.rd_valid(ch1_rd_valid), .rd_data(ch1_rd_data));

	task automatic final_report();
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	task automatic step();
		@(posedge clk);
		#1;
	endtask : step

	task automatic chk_flag(input logic got, input logic exp, input string m);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s got %h", $time, m, got);
		end
	endtask : chk_flag

	task automatic chk_word(input logic [63:0] got, input logic [63:0] exp, input string m);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s got %h", $time, m, got);
		end
	endtask : chk_word

	task automatic setcfg(input dcam_mode_e m, input logic [6:0] s0, input logic [6:0] s1,
		input logic [1:0] dn, input logic [7:0] sp, input logic e);
		cfg_mode = m;
		cfg_ch0_size = s0;
		cfg_ch1_size = s1;
		cfg_density = dn;
		dimm_speed = sp;
		step();
		srst = 1'h1;
		repeat (3) step();
		srst = 1'h0;
		repeat (2) step();
		chk_flag(cfg_error, e, "config refused");
	endtask : setcfg

	task automatic req(input logic [31:0] ad, input logic w, input logic [7:0] be,
		input logic [63:0] d, input logic [1:0] ch);
		int k = 0;
		step();
		req_addr = ad;
		req_write = w;
		req_be = be;
		req_wdata = d;
		req_valid = 1'h1;
		while (req_ready !== 1'h1 && k++ < 40)
			step();
		step();
		req_valid = 1'h0;
		chk_flag(ch0_cmd_valid, ch == 2'h0, "ch0 cmd");
		chk_flag(ch1_cmd_valid, ch == 2'h1, "ch1 cmd");
		chk_flag(resp_err, ch == 2'h2, "range error");
	endtask : req

	task automatic rdchk(input logic [31:0] ad, input logic [1:0] ch, input logic [63:0] e);
		int k = 0;
		req(ad, 1'h0, 8'hFF, 64'h0, ch);
		while (rd_valid !== 1'h1 && k++ < 40)
			step();
		chk_word(rd_data, e, "read data");
	endtask : rdchk

	initial
	begin
		#40000;
		errors++;
		final_report();
	end

	initial
	begin
		setcfg(MODE_SINGLE, 7'h10, 7'h0, DENS_512M, 8'h0F, 1'h0);
		chk_word(64'(mem_speed), 64'h3, "speed");
		chk_flag(ch0_cke, 1'h1, "cke ch0");
		chk_flag(ch1_cke, 1'h0, "cke idle ch1");
		req(32'h100, 1'h0, 8'hFF, 64'h0, 2'h0);
		chk_word(64'(cmd_burst_len), 64'h8, "burst");
		chk_word(64'(cmd_col), 64'h20, "col");
		req(32'h40000000, 1'h0, 8'hFF, 64'h0, 2'h2);
		req(32'h20000000, 1'h0, 8'hFF, 64'h0, 2'h0);
		chk_word(64'(cmd_rank), 64'h1, "rank x8");
		req(32'h8000, 1'h0, 8'hFF, 64'h0, 2'h0);
		chk_word(64'(cmd_bank), 64'h0, "bank 512M");
		req(32'h200, 1'h1, 8'hFF, 64'h0123456789ABCDEF, 2'h0);
		chk_flag(cmd_page_hit, 1'h0, "page miss");
		req(32'h200, 1'h1, 8'h0F, 64'hFEDCBA9876543210, 2'h0);
		chk_word(64'(ch0_dm), 64'hF0, "mask");
		chk_flag(cmd_page_hit, 1'h1, "page hit");
		rdchk(32'h200, 2'h0, 64'h0123456776543210);
		step();
		suspend_req = 1'h1;
		step();
		chk_flag(req_ready, 1'h0, "ready in suspend");
		step();
		chk_flag(suspended, 1'h1, "suspended");
		chk_flag(ch0_cke, 1'h0, "cke in suspend");
		repeat (20) step();
		suspend_req = 1'h0;
		step();
		chk_flag(ch0_cke, 1'h1, "cke resumed");
		chk_flag(req_ready, 1'h1, "ready resumed");
		rdchk(32'h200, 2'h0, 64'h0123456776543210);
		chk_flag(cmd_page_hit, 1'h0, "pages closed by suspend");
		cfg_x16 = 1'h1;
		setcfg(MODE_SINGLE, 7'h10, 7'h0, DENS_512M, 8'h0F, 1'h0);
		req(32'h10000000, 1'h0, 8'hFF, 64'h0, 2'h0);
		chk_word(64'(cmd_rank), 64'h1, "rank x16");
		cfg_x16 = 1'h0;
		setcfg(MODE_SINGLE, 7'h10, 7'h0, DENS_1G, 8'h0F, 1'h0);
		req(32'h8000, 1'h0, 8'hFF, 64'h0, 2'h0);
		chk_word(64'(cmd_bank), 64'h4, "bank 1G");
		setcfg(MODE_SINGLE, 7'h10, 7'h0, 2'h3, 8'h0F, 1'h1);
		cfg_single_ch = 1'h1;
		setcfg(MODE_SINGLE, 7'h10, 7'h0, DENS_512M, 8'h0F, 1'h1);
		setcfg(MODE_SINGLE, 7'h0, 7'h10, DENS_512M, 8'h0F, 1'h0);
		chk_flag(ch0_cke, 1'h0, "cke idle ch0");
		req(32'h300, 1'h1, 8'hFF, 64'h5A5A00FF12345678, 2'h1);
		rdchk(32'h300, 2'h1, 64'h5A5A00FF12345678);
		cfg_single_ch = 1'h0;
		setcfg(MODE_ASYM, 7'h4, 7'h4, DENS_512M, 8'h0F, 1'h0);
		req(32'h0FFFFFC0, 1'h0, 8'hFF, 64'h0, 2'h0);
		req(32'h10000048, 1'h0, 8'hFF, 64'h0, 2'h1);
		chk_word(64'({cmd_row, cmd_col}), 64'h9, "ch1 base");
		req(32'h20000000, 1'h0, 8'hFF, 64'h0, 2'h2);
		setcfg(MODE_INTERLEAVE, 7'h20, 7'h20, DENS_1G, 8'h0F, 1'h0);
		req(32'h40, 1'h0, 8'hFF, 64'h0, 2'h1);
		req(32'h80, 1'h0, 8'hFF, 64'h0, 2'h0);
		chk_word(64'(cmd_col), 64'h8, "col 80");
		for (int i = 0; i < 40; i++)
		begin
			a = {i[3], 14'h0, i[2:0], 7'h0, i[4], 6'h0};
			req(a | (i > 31 ? 32'h20000 : 32'h0), 1'h0, 8'hFF, 64'h0, {1'h0, i[4]});
		end
		repeat (3) step();
		chk_word(64'(open_pages), 64'h20, "open pages");
		setcfg(MODE_INTERLEAVE, 7'h20, 7'h10, DENS_1G, 8'h0F, 1'h1);
		setcfg(MODE_ASYM, 7'h21, 7'h20, DENS_512M, 8'h0F, 1'h1);
		setcfg(MODE_SINGLE, 7'h10, 7'h0, DENS_512M, 8'h06, 1'h0);
		chk_word(64'(mem_speed), 64'h1, "slowest");
		setcfg(MODE_SINGLE, 7'h10, 7'h0, DENS_512M, 8'h39, 1'h0);
		chk_word(64'(mem_speed), 64'h1, "slowest in first slot");
		setcfg(dcam_mode_e'(2'h3), 7'h10, 7'h0, DENS_512M, 8'h0F, 1'h1);
		for (int f = 0; f < 3; f++)
		begin
			{dimm_ecc[1], dimm_registered[0], dimm_cl444[1]} = 3'(1 << f);
			setcfg(MODE_SINGLE, 7'h10, 7'h0, DENS_512M, 8'h0F, 1'h1);
		end
		dimm_ecc = 4'h0;
		cfg_full_variant = 1'h0;
		setcfg(MODE_ASYM, 7'h10, 7'h11, DENS_512M, 8'h0F, 1'h1);
		setcfg(MODE_ASYM, 7'h10, 7'h10, DENS_512M, 8'h0F, 1'h0);
		chk_word(64'(mem_speed), 64'h2, "capped speed");
		req(32'h80000000, 1'h0, 8'hFF, 64'h0, 2'h2);
		final_report();
	end
endmodule : dcam_map_tb_top
`default_nettype wire
